//--- hdl/csc_clock_source_control.sv
// Clock source control: crystal, ring, PLL run/settle state and source select.
// Assumes external sources are sampled pins; oscillators are modelled by enables.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module csc_clock_source_control
    import csc_pkg::*;
#(
    parameter int XO_START_CYC = CSC_XO_START_CYC,
    parameter int PLL_LOCK_CYC = CSC_PLL_LOCK_CYC
)(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire csc_bus_t   bus,
    output var  logic [7:0] rdata,
    input  wire csc_pwr_t   pwr,
    input  wire logic       crystal_input_pin,
    input  wire logic       ext_clock_input_a,
    input  wire logic       ext_clock_input_b,
    input  wire logic       ring_oscillator,
    output var  logic       crystal_oscillator,
    output var  logic       ring_run,
    output var  logic       pll_sys_run,
    output var  logic       pll_usb_run,
    output var  logic       pll_sys_usable,
    output var  logic       pll_usb_usable,
    output var  logic       ref_on_crystal,
    output var  logic       sys_on_pll,
    output var  logic       gp_clock_out,
    output var  logic       irq
);
    logic [7:0]           ctrl_q;
    logic [7:0]           sel_q;
    logic [7:0]           ist_q;
    logic [7:0]           imask_q;
    logic [7:0]           rdata_q;
    logic [CSC_CNT_W-1:0] xo_cnt_q;
    logic [CSC_CNT_W-1:0] ps_cnt_q;
    logic [CSC_CNT_W-1:0] pu_cnt_q;
    logic                 xo_stab_q;
    logic                 ps_lock_q;
    logic                 pu_lock_q;
    logic [2:0]           xi_s_q;
    logic [2:0]           ea_s_q;
    logic [2:0]           eb_s_q;
    logic [2:0]           ro_s_q;
    logic                 xi_f_q;
    logic                 ea_f_q;
    logic                 eb_f_q;
    logic                 ro_f_q;
    logic                 gp_q;
    logic                 irq_q;

    function automatic logic settle(input logic [CSC_CNT_W-1:0] c, input int lim);
        settle = (c >= CSC_CNT_W'(lim));
    endfunction : settle

    // Three-stage pin filter: a new level counts once the last two stages agree.
    // Costs one extra cycle of latency but rejects a metastable single-cycle blip.
    function automatic logic pin_level(input logic [2:0] s, input logic held);
        pin_level = (s[2] == s[1]) ? s[2] : held;
    endfunction : pin_level

    // Register map, all eight bits wide:
    //   0 control: crystal enable, passthrough, ring enable, system and USB PLL enables
    //   1 status, read only: crystal stable, two lock flags, crystal and ring running
    //   2 select: reference on crystal, system on PLL, two bits of output source
    //   3 events: rising stable and lock flags, each cleared by writing a one
    //   4 event mask, same layout as the events
    //   Reads of any other offset return zero and writes there are dropped
    // Register decode
    wire wr_ctrl  = bus.wr && (bus.addr == CSC_ADDR_CTRL);
    wire wr_sel   = bus.wr && (bus.addr == CSC_ADDR_SEL);
    wire wr_ist   = bus.wr && (bus.addr == CSC_ADDR_IRQ_ST);
    wire wr_imask = bus.wr && (bus.addr == CSC_ADDR_IRQ_MK);
    // Crystal runs only when enabled and outside deep stop; config survives deep stop
    wire xo_run   = ctrl_q[CSC_CTRL_XO_EN] && !pwr.deep_stop;
    // Ring stops in deep stop too; only allowed off once ref is on the crystal
    wire ro_run   = ctrl_q[CSC_CTRL_RO_EN] && !pwr.deep_stop;
    // PLL enables ignore sleep and deep stop entirely; software must stop them
    wire ps_run   = ctrl_q[CSC_CTRL_PLLS_EN];
    wire pu_run   = ctrl_q[CSC_CTRL_PLLU_EN];
    // Passthrough skips the crystal startup wait, as the pin clock is already good
    wire xo_good  = xo_run && (ctrl_q[CSC_CTRL_XO_PASS] || settle(xo_cnt_q, XO_START_CYC));
    // PLL reference disappears with the crystal, so lock is lost with it
    wire ps_good  = ps_run && xo_stab_q && settle(ps_cnt_q, PLL_LOCK_CYC);
    wire pu_good  = pu_run && xo_stab_q && settle(pu_cnt_q, PLL_LOCK_CYC);
    wire [7:0] st_now = {3'h0, ro_run, xo_run, pu_lock_q, ps_lock_q, xo_stab_q};
    wire [7:0] ev = {5'h0, pu_good & ~pu_lock_q, ps_good & ~ps_lock_q, xo_good & ~xo_stab_q};
    // Crystal source: passthrough forwards the synchronised pin level
    wire xo_clk   = xo_run && xi_f_q;
    wire [1:0] gp_src = sel_q[CSC_SEL_GP_LO +: 2];
    // Selecting the crystal before it is stable falls back to the ring source
    wire ref_xo   = sel_q[CSC_SEL_REF_XO] && xo_stab_q;
    wire sys_pll  = sel_q[CSC_SEL_SYS_PLL] && ps_lock_q;
    // Crystal reaches the pin only through the gp generator mux
    wire gp_d     = (gp_src == CSC_GP_XO)   ? (xo_clk && xo_stab_q) :
                    (gp_src == CSC_GP_EXTA) ? ea_f_q :
                    (gp_src == CSC_GP_EXTB) ? eb_f_q : (ro_run && ro_f_q);
    wire [7:0] rd_mux = (bus.addr == CSC_ADDR_CTRL)   ? ctrl_q  :
                        (bus.addr == CSC_ADDR_STATUS) ? st_now  :
                        (bus.addr == CSC_ADDR_SEL)    ? sel_q   :
                        (bus.addr == CSC_ADDR_IRQ_ST) ? ist_q   :
                        (bus.addr == CSC_ADDR_IRQ_MK) ? imask_q : 8'h00;

    // Pin synchronisers; external sources run regardless of power state
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            xi_s_q <= 3'h0;
            ea_s_q <= 3'h0;
            eb_s_q <= 3'h0;
            ro_s_q <= 3'h0;
        end
        else
        begin
            xi_s_q <= {xi_s_q[1:0], crystal_input_pin};
            ea_s_q <= {ea_s_q[1:0], ext_clock_input_a};
            eb_s_q <= {eb_s_q[1:0], ext_clock_input_b};
            ro_s_q <= {ro_s_q[1:0], ring_oscillator};
        end
    end

    // Filtered pin levels; only the last two stages are read, never the first
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            xi_f_q <= 1'b0;
            ea_f_q <= 1'b0;
            eb_f_q <= 1'b0;
            ro_f_q <= 1'b0;
        end
        else
        begin
            xi_f_q <= pin_level(xi_s_q, xi_f_q);
            ea_f_q <= pin_level(ea_s_q, ea_f_q);
            eb_f_q <= pin_level(eb_s_q, eb_f_q);
            ro_f_q <= pin_level(ro_s_q, ro_f_q);
        end
    end

    // Software registers; ring enable can only drop once ref is on the crystal
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_q  <= CSC_CTRL_RST;
            sel_q   <= 8'h00;
            imask_q <= 8'h00;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= bus.wdata | {5'h0, !ref_xo, 2'h0};
            if (wr_sel)
                sel_q <= bus.wdata;
            if (wr_imask)
                imask_q <= bus.wdata;
        end
    end

    // Settle counters restart whenever their source stops
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            xo_cnt_q <= '0;
            ps_cnt_q <= '0;
            pu_cnt_q <= '0;
        end
        else
        begin
            xo_cnt_q <= !xo_run ? '0 : (xo_good ? xo_cnt_q : xo_cnt_q + 1'b1);
            ps_cnt_q <= !(ps_run && xo_stab_q) ? '0 : (ps_good ? ps_cnt_q : ps_cnt_q + 1'b1);
            pu_cnt_q <= !(pu_run && xo_stab_q) ? '0 : (pu_good ? pu_cnt_q : pu_cnt_q + 1'b1);
        end
    end

    // Status flags and sticky events; a new event wins over a write-one clear
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            xo_stab_q <= 1'b0;
            ps_lock_q <= 1'b0;
            pu_lock_q <= 1'b0;
            ist_q     <= 8'h00;
        end
        else
        begin
            xo_stab_q <= xo_good;
            ps_lock_q <= ps_good;
            pu_lock_q <= pu_good;
            ist_q     <= (ist_q & ~(wr_ist ? bus.wdata : 8'h00)) | ev;
        end
    end

    // Registered outputs
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata_q            <= 8'h00;
            gp_q               <= 1'b0;
            irq_q              <= 1'b0;
            crystal_oscillator <= 1'b0;
            ring_run           <= 1'b1;
            pll_sys_run        <= 1'b0;
            pll_usb_run        <= 1'b0;
            pll_sys_usable     <= 1'b0;
            pll_usb_usable     <= 1'b0;
            ref_on_crystal     <= 1'b0;
            sys_on_pll         <= 1'b0;
        end
        else
        begin
            rdata_q            <= bus.rd ? rd_mux : 8'h00;
            gp_q               <= gp_d;
            irq_q              <= |(ist_q & imask_q);
            crystal_oscillator <= xo_run;
            ring_run           <= ro_run;
            pll_sys_run        <= ps_run;
            pll_usb_run        <= pu_run;
            pll_sys_usable     <= ps_lock_q;
            pll_usb_usable     <= pu_lock_q;
            ref_on_crystal     <= ref_xo;
            sys_on_pll         <= sys_pll;
        end
    end
    // Outputs leave straight from their flops
    assign rdata        = rdata_q;
    assign gp_clock_out = gp_q;
    assign irq          = irq_q;

    // Checks
    xo_off_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ctrl_q[CSC_CTRL_XO_EN] |=> !crystal_oscillator) else $error("crystal ran unenabled");
    xo_deep_a: assert property (@(posedge clk) disable iff (sys_rst)
        pwr.deep_stop |=> !crystal_oscillator && !xo_stab_q) else $error("crystal ran in deep stop");
    xo_sleep_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl_q[CSC_CTRL_XO_EN] && !pwr.deep_stop |=> crystal_oscillator) else $error("crystal stopped");
    pll_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(pll_sys_usable) |-> $past(ps_lock_q) && pll_sys_run) else $error("pll used unlocked");
    pll_deep_a: assert property (@(posedge clk) disable iff (sys_rst)
        pwr.deep_stop |=> pll_sys_run == $past(ctrl_q[CSC_CTRL_PLLS_EN])) else $error("pll auto changed");
    ref_xo_a: assert property (@(posedge clk) disable iff (sys_rst)
        ref_on_crystal |-> $past(xo_stab_q)) else $error("ref on unstable crystal");
    flag_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        !xo_run |=> !xo_stab_q ##1 !ps_lock_q) else $error("flag set while stopped");
    gp_xo_a: assert property (@(posedge clk) disable iff (sys_rst)
        gp_src == CSC_GP_XO && !xo_stab_q |=> !gp_clock_out) else $error("raw crystal on pin");
    ext_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
        gp_src == CSC_GP_EXTA |=> gp_clock_out == $past(ea_f_q)) else $error("ext clock blocked");
    irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        |(ist_q & imask_q) |=> irq) else $error("irq missing");

    // PLL checks
    usb_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(pll_usb_usable) |-> $past(pu_lock_q) && pll_usb_run) else $error("usb pll used unlocked");
    sleep_pll_a: assert property (@(posedge clk) disable iff (sys_rst)
        pwr.sleep && ctrl_q[CSC_CTRL_PLLU_EN] |=> pll_usb_run) else $error("pll stopped in sleep");
    usb_deep_a: assert property (@(posedge clk) disable iff (sys_rst)
        pwr.deep_stop |=> pll_usb_run == $past(ctrl_q[CSC_CTRL_PLLU_EN])) else $error("usb pll changed");
    sys_pll_a: assert property (@(posedge clk) disable iff (sys_rst)
        sys_on_pll |-> $past(ps_lock_q)) else $error("sys on unlocked pll");
    lock_xo_a: assert property (@(posedge clk) disable iff (sys_rst)
        ps_lock_q |-> $past(xo_stab_q)) else $error("sys lock without crystal");
    usb_xo_a: assert property (@(posedge clk) disable iff (sys_rst)
        pu_lock_q |-> $past(xo_stab_q)) else $error("usb lock without crystal");
    usb_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        !xo_run |=> !xo_stab_q ##1 !pu_lock_q) else $error("usb lock while stopped");

    // Register and event checks
    event_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
        ev[CSC_ST_XO_STABLE] |=> ist_q[CSC_ST_XO_STABLE]) else $error("event lost");
    ist_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_ist && bus.wdata[CSC_ST_XO_STABLE] && !ev[CSC_ST_XO_STABLE]
        |=> !ist_q[CSC_ST_XO_STABLE]) else $error("event not cleared");
    rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
        !bus.rd |=> rdata == 8'h00) else $error("read data outside read");
    ctrl_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_ctrl && ref_xo |=> ctrl_q == $past(bus.wdata)) else $error("control write lost");
    ring_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_ctrl && !ref_xo |=> ctrl_q[CSC_CTRL_RO_EN]) else $error("ring stopped too early");
    irq_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        !(|(ist_q & imask_q)) |=> !irq) else $error("irq without event");

    // Source and routing checks
    pass_stable_a: assert property (@(posedge clk) disable iff (sys_rst)
        xo_run && ctrl_q[CSC_CTRL_XO_PASS] |=> xo_stab_q) else $error("passthrough not stable");
    ext_b_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
        gp_src == CSC_GP_EXTB |=> gp_clock_out == $past(eb_f_q)) else $error("ext b blocked");
    gp_ring_a: assert property (@(posedge clk) disable iff (sys_rst)
        gp_src == CSC_GP_RING && !ro_run |=> !gp_clock_out) else $error("stopped ring on pin");
    ring_deep_a: assert property (@(posedge clk) disable iff (sys_rst)
        pwr.deep_stop |=> !ring_run) else $error("ring ran in deep stop");

    // Scenario covers
    stable_cov: cover property (@(posedge clk) disable iff (sys_rst) $rose(xo_stab_q));
    lock_cov: cover property (@(posedge clk) disable iff (sys_rst) $rose(ps_lock_q));
    deep_cov: cover property (@(posedge clk) disable iff (sys_rst) xo_stab_q ##1 pwr.deep_stop);
    usb_cov: cover property (@(posedge clk) disable iff (sys_rst) $rose(pu_lock_q));
    pass_cov: cover property (@(posedge clk) disable iff (sys_rst) ctrl_q[CSC_CTRL_XO_PASS] && xo_stab_q);
endmodule : csc_clock_source_control
`default_nettype wire

//--- hdl/csc_pkg.sv
// Constants, register map and status layout of the clock source control block.
// Assumes one 100 MHz system clock and a simple strobe register port.
// Overview of operation
// - Crystal oscillator is off after reset until software enables it.
// - Crystal runs through light sleep, stops in deep stop, restarts as configured.
// - Passthrough setting forwards the crystal input pin as an external clock.
// - External clocks pass unchanged through light sleep and deep stop.
// - PLL output is unusable after start until its locked flag sets.
// - PLLs run through sleep and are not auto stopped in deep stop.
// - Reference may switch to stable crystal, system clock to locked PLL; ring may stop.
// - Crystal clock reaches pins only through general purpose output generators.
// - The one generator has only a source mux: ring, crystal, ext a or ext b.
package csc_pkg;
    localparam logic [3:0] CSC_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] CSC_ADDR_STATUS = 4'h1;
    localparam logic [3:0] CSC_ADDR_SEL    = 4'h2;
    localparam logic [3:0] CSC_ADDR_IRQ_ST = 4'h3;
    localparam logic [3:0] CSC_ADDR_IRQ_MK = 4'h4;
    // Control bits
    localparam int CSC_CTRL_XO_EN   = 0;
    localparam int CSC_CTRL_XO_PASS = 1;
    localparam int CSC_CTRL_RO_EN   = 2;
    localparam int CSC_CTRL_PLLS_EN = 3;
    localparam int CSC_CTRL_PLLU_EN = 4;
    localparam logic [7:0] CSC_CTRL_RST = 8'h04;
    // Status and event bits
    localparam int CSC_ST_XO_STABLE = 0;
    localparam int CSC_ST_PLLS_LOCK = 1;
    localparam int CSC_ST_PLLU_LOCK = 2;
    localparam int CSC_ST_XO_RUN    = 3;
    localparam int CSC_ST_RO_RUN    = 4;
    // Select register: bit0 ref on crystal, bit1 sys on PLL, bits 3:2 gp output source
    localparam int CSC_SEL_REF_XO = 0;
    localparam int CSC_SEL_SYS_PLL = 1;
    localparam int CSC_SEL_GP_LO  = 2;
    localparam logic [1:0] CSC_GP_RING = 2'h0;
    localparam logic [1:0] CSC_GP_XO   = 2'h1;
    localparam logic [1:0] CSC_GP_EXTA = 2'h2;
    localparam logic [1:0] CSC_GP_EXTB = 2'h3;
    // Settle times
    localparam int CSC_CLK_MHZ      = 100;
    localparam int CSC_XO_START_US  = 1000;
    localparam int CSC_PLL_LOCK_US  = 100;
    localparam int CSC_XO_START_CYC = CSC_XO_START_US * CSC_CLK_MHZ;
    localparam int CSC_PLL_LOCK_CYC = CSC_PLL_LOCK_US * CSC_CLK_MHZ;
    localparam int CSC_CNT_W        = 24;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } csc_bus_t;
    typedef struct packed {
        logic sleep;
        logic deep_stop;
    } csc_pwr_t;
endpackage : csc_pkg

//--- sim/csc_clock_source_control_tb.sv
// Self-checking bench for the clock source control block.
// Assumes short settle counts so the crystal and the PLLs settle within a few cycles.
`timescale 1ns/10ps
`default_nettype none
module csc_clock_source_control_tb
    import csc_pkg::*;
;
    logic       clk       = 1'b0;
    logic       sys_rst   = 1'b1;
    csc_bus_t   bus       = '0;
    csc_pwr_t   pwr       = '0;
    logic [3:0] pins      = 4'h0; // Ext b, ext a, crystal pin, ring
    logic [7:0] rdata;
    logic [7:0] rd_v;
    logic       xo_run, ring_run, ps_run, pu_run, ps_use, pu_use, ref_xo, sys_pll, gp_out, irq;
    int         failures  = 0;
    int         tests_run = 0;
    int         cycles    = 0;

    csc_clock_source_control #(.XO_START_CYC(8), .PLL_LOCK_CYC(4)) dut (
        .clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .pwr(pwr),
        .crystal_input_pin(pins[1]), .ext_clock_input_a(pins[2]),
        .ext_clock_input_b(pins[3]), .ring_oscillator(pins[0]),
        .crystal_oscillator(xo_run), .ring_run(ring_run), .pll_sys_run(ps_run),
        .pll_usb_run(pu_run), .pll_sys_usable(ps_use), .pll_usb_usable(pu_use),
        .ref_on_crystal(ref_xo), .sys_on_pll(sys_pll), .gp_clock_out(gp_out), .irq(irq));

    // Free running 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    // Hang guard: the sequence needs under two thousand cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("counts: compares=%0d mismatches=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    // One-cycle strobes; a gap cycle follows so a strobe is never assigned twice at one edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus <= '0;
        #1;
        rd_v = rdata;
    endtask : rd

    // Bounded poll of one status bit
    task automatic wait_st(input int b);
        int n;
        n = 0;
        rd(CSC_ADDR_STATUS);
        while (rd_v[b] !== 1'b1 && n < 40)
        begin
            rd(CSC_ADDR_STATUS);
            n = n + 1;
        end
        chk(8'h01, {7'h0, rd_v[b]});
    endtask : wait_st

    function automatic logic exp_gp(input logic [1:0] src, input logic [3:0] p);
        return p[src];
    endfunction : exp_gp

    // Random pin levels, each held long enough to clear the input synchronisers
    task automatic gp_run(input int lo);
        for (int s = lo; s < 4; s++)
        begin
            wr(CSC_ADDR_SEL, {4'h0, s[1:0], 2'b00});
            repeat (6)
            begin
                @(posedge clk);
                pins <= 4'($urandom);
                repeat (7) @(posedge clk);
                #1;
                chk({7'h0, exp_gp(s[1:0], pins)}, {7'h0, gp_out});
            end
        end
    endtask : gp_run

    // Main sequence
    initial
    begin
        void'($urandom(32'h5c9d));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk(8'h00, {7'h0, xo_run});
        chk(8'h01, {7'h0, ring_run});
        rd(CSC_ADDR_CTRL);
        chk(CSC_CTRL_RST, rd_v);
        rd(CSC_ADDR_STATUS);
        chk(8'h10, rd_v);
        wr(4'hf, 8'hff);
        rd(4'hf);
        chk(8'h00, rd_v);
        $display("test reset done");
        wr(CSC_ADDR_CTRL, 8'h05);
        rd(CSC_ADDR_STATUS);
        chk(8'h00, {7'h0, rd_v[CSC_ST_XO_STABLE]});
        wait_st(CSC_ST_XO_STABLE);
        chk(8'h01, {7'h0, xo_run});
        rd(CSC_ADDR_IRQ_ST);
        chk(8'h01, rd_v);
        chk(8'h00, {7'h0, irq});
        wr(CSC_ADDR_IRQ_MK, 8'h01);
        @(posedge clk);
        #1;
        chk(8'h01, {7'h0, irq});
        wr(CSC_ADDR_IRQ_ST, 8'h01);
        @(posedge clk);
        #1;
        chk(8'h00, {7'h0, irq});
        wr(CSC_ADDR_IRQ_MK, 8'h00);
        $display("test crystal start done");
        wr(CSC_ADDR_CTRL, 8'h1d);
        #1;
        chk(8'h00, {6'h0, pu_use, ps_use});
        wait_st(CSC_ST_PLLS_LOCK);
        repeat (2) @(posedge clk);
        #1;
        chk(8'h03, {6'h0, pu_use, ps_use});
        rd(CSC_ADDR_IRQ_ST);
        chk(8'h06, rd_v);
        @(posedge clk);
        pwr <= '{sleep: 1'b1, deep_stop: 1'b0};
        repeat (20) @(posedge clk);
        #1;
        chk(8'h07, {5'h0, pu_run, ps_run, xo_run});
        @(posedge clk);
        pwr <= '0;
        wr(CSC_ADDR_SEL, 8'h03);
        @(posedge clk);
        #1;
        chk(8'h03, {6'h0, sys_pll, ref_xo});
        wr(CSC_ADDR_CTRL, 8'h19);
        @(posedge clk);
        #1;
        chk(8'h00, {7'h0, ring_run});
        $display("test pll and sleep done");
        wr(CSC_ADDR_SEL, 8'h01);
        wr(CSC_ADDR_CTRL, 8'h01);
        @(posedge clk);
        pwr <= '{sleep: 1'b1, deep_stop: 1'b0};
        repeat (4) @(posedge clk);
        #1;
        chk(8'h01, {5'h0, pu_run, ps_run, xo_run});
        @(posedge clk);
        pwr <= '{sleep: 1'b0, deep_stop: 1'b1};
        repeat (4) @(posedge clk);
        #1;
        chk(8'h00, {5'h0, pu_run, ps_run, xo_run});
        gp_run(2);
        @(posedge clk);
        pwr <= '0;
        wait_st(CSC_ST_XO_STABLE);
        chk(8'h01, {5'h0, pu_run, ps_run, xo_run});
        $display("test deep stop done");
        wr(CSC_ADDR_CTRL, 8'h07);
        gp_run(0);
        $display("test clock routing done");
        wrap_up();
    end
endmodule : csc_clock_source_control_tb
`default_nettype wire
